// >>> hw/tmr1_cfg.svh
// Notes on behaviour
// - reading count low byte returns low byte of live 16-bit count
// - reading count low byte snapshots upper byte for later high-byte reads
// - a write to count low byte with byte enable 0 set clears the whole count to zero
// - control bits 7,6,5 hold channel 2,1,0 pending flags, cleared by 0
// - wrap flag bit 4 sets at terminal count, or zero turnaround up/down
// - prescale 00/01/10/11 advances every 1/8/32/128 ticks
// - writing prescale never resets the prescale counter
// - mode 00 holds the count and stops counting
// - mode 01 counts 0 to 0xFFFF then wraps to zero, forever
// - mode 10 counts 0 to channel 0 compare value then restarts
// - mode 11 counts up to compare value, back down to zero, repeating
// - setup bit 7 picks capture trigger: pin, or masked radio events
// - setup bit 6 is channel 0 interrupt enable, reset value 1
// - action 000 set, 001 clear, 010 toggle output on match; 101-111 none
// - action 011 sets on up match, clears at zero or on down match
// - action 100 clears on up match, sets at zero or on down match
// - setup bit 2 selects capture (0) or compare (1) function
// - edge field: 00 off, 01 rising, 10 falling, 11 both edges
// - wrap and channel flags set regardless of interrupt enable bits
// - up/down with compare channel 0: chan0 and wrap flags set at zero
// - any nonzero mode starts counting from the current value
`ifndef TMR1_CFG_SVH
`define TMR1_CFG_SVH

// ============================================================
// register indices, byte address is four times the index
`define TMR1_IDX_CNT_LOW 8'hE2
`define TMR1_IDX_CNT_HIGH 8'hE3
`define TMR1_IDX_CTL 8'hE4
`define TMR1_IDX_SETUP 8'hE5
`define TMR1_ADDR_W 10

// ============================================================
// reset values
`define TMR1_CTL_RST 8'h00
`define TMR1_SETUP_RST 8'h40
`define TMR1_CNT_RST 16'h0000

// ============================================================
// field codes
`define TMR1_MODE_STOP 2'h0
`define TMR1_MODE_FREE 2'h1
`define TMR1_MODE_MODULO 2'h2
`define TMR1_MODE_UPDOWN 2'h3
`define TMR1_DIV_1 2'h0
`define TMR1_DIV_8 2'h1
`define TMR1_DIV_32 2'h2
`define TMR1_MASK_8 7'h07
`define TMR1_MASK_32 7'h1F
`define TMR1_MASK_128 7'h7F
`define TMR1_ACT_SET 3'h0
`define TMR1_ACT_CLR 3'h1
`define TMR1_ACT_TOG 3'h2
`define TMR1_ACT_SET_UP 3'h3
`define TMR1_ACT_CLR_UP 3'h4
`define TMR1_EDGE_OFF 2'h0
`define TMR1_EDGE_RISE 2'h1
`define TMR1_EDGE_FALL 2'h2
`define TMR1_CNT_MAX 16'hFFFF
`define TMR1_CNT_ONE 16'h0001

`endif

// >>> hw/tmr1_core.sv
`timescale 1ns/1ps
`include "tmr1_cfg.svh"

module tmr1_core (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`TMR1_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tick_enable,
    input wire logic [15:0] period_compare_value,
    input wire logic capture_pin,
    input wire logic [7:0] radio_events,
    input wire logic [7:0] radio_event_mask,
    input wire logic chan1_event,
    input wire logic chan2_event,
    output logic chan0_out,
    output logic [15:0] capture_value,
    output logic capture_strobe,
    output logic [15:0] tick_count,
    output logic chan0_irq_enable,
    output logic [3:0] event_flags
);

    // ============================================================
    // state
    tmr1_pkg::tmr1_ctl_t ctl;
    tmr1_pkg::tmr1_setup_t setup;
    tmr1_pkg::tmr1_bus_state_t bus_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic count_down;
    logic next_down;
    logic [6:0] prescale;
    logic [7:0] count_high_snapshot;
    logic cap_meta;
    logic cap_sync;
    logic cap_prev;

    // ============================================================
    // bus decode
    function automatic logic hit(input logic [`TMR1_ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    logic req;
    logic take;
    logic first;
    logic wr_low;
    logic wr_ctl;
    logic wr_setup;
    logic rd_low;


    // one wait state for every access, writes land on the accepting edge
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & (bus_state == tmr1_pkg::tmr1_bus_idle);
    assign take = req & (bus_state == tmr1_pkg::tmr1_bus_ack);
    assign first = req & (bus_state == tmr1_pkg::tmr1_bus_idle);
    assign wr_low = take & avs_write & avs_byteenable[0]
                    & hit(avs_address, `TMR1_IDX_CNT_LOW);
    assign wr_ctl = take & avs_write & avs_byteenable[0]
                    & hit(avs_address, `TMR1_IDX_CTL);
    assign wr_setup = take & avs_write & avs_byteenable[0]
                      & hit(avs_address, `TMR1_IDX_SETUP);
    assign rd_low = first & avs_read & hit(avs_address, `TMR1_IDX_CNT_LOW);

    always_ff @(posedge clk) begin
        if (reset) begin
            bus_state <= tmr1_pkg::tmr1_bus_idle;
        end else if (first) begin
            bus_state <= tmr1_pkg::tmr1_bus_ack;
        end else begin
            bus_state <= tmr1_pkg::tmr1_bus_idle;
        end
    end

    // ============================================================
    // read data, captured in the cycle before the accepting edge
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (first & avs_read) begin
            if (hit(avs_address, `TMR1_IDX_CNT_LOW)) begin
                avs_readdata <= {24'h000000, count[7:0]};
            end else if (hit(avs_address, `TMR1_IDX_CNT_HIGH)) begin
                avs_readdata <= {24'h000000, count_high_snapshot};
            end else if (hit(avs_address, `TMR1_IDX_CTL)) begin
                avs_readdata <= {24'h000000, ctl};
            end else if (hit(avs_address, `TMR1_IDX_SETUP)) begin
                avs_readdata <= {24'h000000, setup};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_high_snapshot <= 8'h00;
        end else if (rd_low) begin
            count_high_snapshot <= count[15:8];
        end
    end

    // ============================================================
    // prescaler, free running on ticks
    logic advance;
    logic running;

    always_ff @(posedge clk) begin
        if (reset) begin
            prescale <= 7'h00;
        end else if (tick_enable) begin
            prescale <= prescale + 7'h01;
        end
    end

    always_comb begin
        case (ctl.div)
            `TMR1_DIV_1: advance = tick_enable;
            `TMR1_DIV_8: advance = tick_enable
                & ((prescale & `TMR1_MASK_8) == `TMR1_MASK_8);
            `TMR1_DIV_32: advance = tick_enable
                & ((prescale & `TMR1_MASK_32) == `TMR1_MASK_32);
            default: advance = tick_enable
                & (prescale == `TMR1_MASK_128);
        endcase
    end


    // a nonzero mode resumes from the held count
    assign running = (ctl.mode != `TMR1_MODE_STOP);

    // ============================================================
    // counter
    logic wrap_evt;
    logic up_match;
    logic down_match;
    logic zero_hit;

    always_comb begin
        next_count = count;
        next_down = count_down;
        wrap_evt = 1'b0;
        case (ctl.mode)
            `TMR1_MODE_FREE: begin
                next_down = 1'b0;
                next_count = count + 16'h0001;
                wrap_evt = (count == `TMR1_CNT_MAX);
            end
            `TMR1_MODE_MODULO: begin
                next_down = 1'b0;
                if (count >= period_compare_value) begin
                    next_count = `TMR1_CNT_RST;
                    wrap_evt = 1'b1;
                end else begin
                    next_count = count + 16'h0001;
                end
            end
            `TMR1_MODE_UPDOWN: begin
                if (!count_down) begin
                    if (count >= period_compare_value) begin
                        next_down = (count != `TMR1_CNT_RST);
                        next_count = (count == `TMR1_CNT_RST) ? count
                                     : count - 16'h0001;
                    end else begin
                        next_count = count + 16'h0001;
                    end
                end else if (count <= `TMR1_CNT_ONE) begin
                    next_count = `TMR1_CNT_RST;
                    next_down = 1'b0;
                    wrap_evt = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            default: begin
                next_count = count;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= `TMR1_CNT_RST;
            count_down <= 1'b0;
        end else if (wr_low) begin
            count <= `TMR1_CNT_RST;
            count_down <= 1'b0;
        end else if (advance & running) begin
            count <= next_count;
            count_down <= next_down;
        end
    end

    logic step;
    assign step = advance & running & ~wr_low;
    assign up_match = step & ~next_down
                      & (next_count == period_compare_value);
    assign down_match = step & next_down & count_down
                        & (next_count == period_compare_value);
    assign zero_hit = step & (next_count == `TMR1_CNT_RST);

    // ============================================================
    // capture trigger
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_meta <= 1'b0;
            cap_sync <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            cap_meta <= capture_pin;
            cap_sync <= cap_meta;
            cap_prev <= cap_sync;
        end
    end

    logic pin_edge;
    logic capture_evt;
    logic radio_hit;

    assign radio_hit = |(radio_events & radio_event_mask);

    always_comb begin
        case (setup.edge_trigger_select)
            `TMR1_EDGE_OFF: pin_edge = 1'b0;
            `TMR1_EDGE_RISE: pin_edge = cap_sync & ~cap_prev;
            `TMR1_EDGE_FALL: pin_edge = ~cap_sync & cap_prev;
            default: pin_edge = cap_sync ^ cap_prev;
        endcase
    end

    assign capture_evt = ~setup.compare_sel
        & (setup.edge_trigger_select != `TMR1_EDGE_OFF)
        & (setup.trigger_source_choice
           ? radio_hit : pin_edge);

    always_ff @(posedge clk) begin
        if (reset) begin
            capture_value <= `TMR1_CNT_RST;
            capture_strobe <= 1'b0;
        end else begin
            capture_strobe <= capture_evt;
            if (capture_evt) begin
                capture_value <= count;
            end
        end
    end

    // ============================================================
    // channel 0 flag source
    logic chan0_evt;
    logic updown;
    assign updown = (ctl.mode == `TMR1_MODE_UPDOWN);
    assign chan0_evt = capture_evt
        | (setup.compare_sel & (updown ? (step & wrap_evt)
                                       : (up_match | down_match)));

    // ============================================================
    // control register and flags; set wins over a clearing write
    logic clr_chan2;
    logic clr_chan1;
    logic clr_chan0;
    logic clr_wrap;

    assign clr_chan2 = wr_ctl & ~avs_writedata[7];
    assign clr_chan1 = wr_ctl & ~avs_writedata[6];
    assign clr_chan0 = wr_ctl & ~avs_writedata[5];
    assign clr_wrap = wr_ctl & ~avs_writedata[4];

    always_ff @(posedge clk) begin
        if (reset) begin
            ctl <= `TMR1_CTL_RST;
        end else begin
            if (wr_ctl) begin
                ctl.div <= avs_writedata[3:2];
                ctl.mode <= avs_writedata[1:0];
            end
            ctl.chan2_event_flag <= chan2_event
                | (ctl.chan2_event_flag & ~clr_chan2);
            ctl.chan1_event_flag <= chan1_event
                | (ctl.chan1_event_flag & ~clr_chan1);
            ctl.chan0_event_flag <= chan0_evt
                | (ctl.chan0_event_flag & ~clr_chan0);
            ctl.wrap_flag <= (step & wrap_evt)
                | (ctl.wrap_flag & ~clr_wrap);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            setup <= `TMR1_SETUP_RST;
        end else if (wr_setup) begin
            setup <= avs_writedata[7:0];
        end
    end

    // ============================================================
    // compare output
    logic any_match;
    logic far_match;

    assign any_match = up_match | down_match;
    assign far_match = updown ? down_match : zero_hit;

    always_ff @(posedge clk) begin
        if (reset) begin
            chan0_out <= 1'b0;
        end else if (setup.compare_sel) begin
            case (setup.output_action_select)
                `TMR1_ACT_SET: begin
                    if (any_match) begin
                        chan0_out <= 1'b1;
                    end
                end
                `TMR1_ACT_CLR: begin
                    if (any_match) begin
                        chan0_out <= 1'b0;
                    end
                end
                `TMR1_ACT_TOG: begin
                    if (any_match) begin
                        chan0_out <= ~chan0_out;
                    end
                end
                `TMR1_ACT_SET_UP: begin
                    if (up_match) begin
                        chan0_out <= 1'b1;
                    end else if (far_match) begin
                        chan0_out <= 1'b0;
                    end
                end
                `TMR1_ACT_CLR_UP: begin
                    if (up_match) begin
                        chan0_out <= 1'b0;
                    end else if (far_match) begin
                        chan0_out <= 1'b1;
                    end
                end
                default: begin
                    // reserved codes leave the pin alone
                    chan0_out <= chan0_out;
                end
            endcase
        end
    end

    // ============================================================
    // status outputs
    assign tick_count = count;
    assign chan0_irq_enable = setup.irq_enable_bit;
    assign event_flags = {ctl.chan2_event_flag, ctl.chan1_event_flag,
                          ctl.chan0_event_flag, ctl.wrap_flag};

endmodule

// >>> hw/tmr1_pkg.sv
package tmr1_pkg;

    // ============================================================
    // control and status byte
    typedef struct packed {
        logic chan2_event_flag;
        logic chan1_event_flag;
        logic chan0_event_flag;
        logic wrap_flag;
        logic [1:0] div;
        logic [1:0] mode;
    } tmr1_ctl_t;

    // ============================================================
    // channel 0 setup byte
    typedef struct packed {
        logic trigger_source_choice;
        logic irq_enable_bit;
        logic [2:0] output_action_select;
        logic compare_sel;
        logic [1:0] edge_trigger_select;
    } tmr1_setup_t;

    // ============================================================
    // bus access phases
    typedef enum logic [1:0] {
        tmr1_bus_idle,
        tmr1_bus_ack
    } tmr1_bus_state_t;

endpackage

// >>> tb/timer1_counter_channel0_test.sv
`timescale 1ns/1ps
`include "tmr1_cfg.svh"
module timer1_counter_channel0_test;
    localparam logic [7:0] idx_lo = `TMR1_IDX_CNT_LOW;
    localparam logic [7:0] idx_hi = `TMR1_IDX_CNT_HIGH;
    localparam logic [7:0] idx_ctl = `TMR1_IDX_CTL;
    localparam logic [7:0] idx_set = `TMR1_IDX_SETUP;
    logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [`TMR1_ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF, event_flags;
    logic avs_waitrequest, tick_enable = 1'b0, capture_pin, pin_level = 1'b0;
    logic [15:0] period_compare_value = 16'h0000, capture_value, tick_count;
    logic [7:0] radio_events = 8'h00, radio_event_mask = 8'h01, out_edges;
    logic chan1_event = 1'b0, chan2_event = 1'b0, chan0_out;
    logic capture_strobe, chan0_irq_enable;
    int fail_count = 0, num_checks = 0, cycles = 0;
    always #2 clk = ~clk;
    tmr1_core i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .tick_enable, .period_compare_value, .capture_pin, .radio_events,
        .radio_event_mask, .chan1_event, .chan2_event, .chan0_out,
        .capture_value, .capture_strobe, .tick_count, .chan0_irq_enable,
        .event_flags);
    tmr1_pin_partner i_pins (.clk, .pin_level, .chan0_out, .capture_pin,
        .out_edges);
    // ============================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        check(avs_readdata, {24'h000000, exp});
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick_enable <= 1'b1;
        end
        @(posedge clk);
        tick_enable <= 1'b0;
    endtask
    task automatic restart(input logic [7:0] ctl);
        wr(idx_ctl, 8'h00);
        wr(idx_lo, 8'h00);
        wr(idx_ctl, ctl);
    endtask
    task automatic out_chk(input logic exp);
        repeat (3) @(posedge clk);
        check(chan0_out, exp);
    endtask
    task automatic pin(input logic v);
        @(posedge clk);
        pin_level <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic radio(input logic [7:0] m);
        @(posedge clk);
        radio_events <= m;
        @(posedge clk);
        radio_events <= 8'h00;
        repeat (6) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ============================================================
    // scenarios
    task automatic t_regs();
        rd_chk(idx_lo, 8'h00);
        rd_chk(idx_hi, 8'h00);
        rd_chk(idx_ctl, 8'h00);
        avs_byteenable <= 4'hE;
        wr(idx_set, 8'h00);
        avs_byteenable <= 4'hF;
        rd_chk(idx_set, 8'h40);
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
    endtask
    task automatic t_prescale();
        logic [7:0] exp [4] = '{8'h80, 8'h10, 8'h04, 8'h01};
        for (int d = 0; d < 4; d++) begin
            restart({4'h0, d[1:0], 2'b01});
            ticks(128);
            wr(idx_ctl, 8'h00);
            rd_chk(idx_lo, exp[d]);
        end
        ticks(9);
        rd_chk(idx_lo, 8'h01);
    endtask
    task automatic t_snapshot();
        restart(8'h01);
        ticks(291);
        rd_chk(idx_lo, 8'h23);
        ticks(256);
        rd_chk(idx_hi, 8'h01);
        rd_chk(idx_lo, 8'h23);
        rd_chk(idx_hi, 8'h02);
        wr(idx_lo, 8'h5A);
        rd_chk(idx_lo, 8'h00);
        rd_chk(idx_hi, 8'h00);
    endtask
    task automatic t_modulo();
        period_compare_value <= 16'h0005;
        restart(8'h02);
        ticks(5);
        rd_chk(idx_lo, 8'h05);
        rd_chk(idx_ctl, 8'h02);
        ticks(1);
        rd_chk(idx_lo, 8'h00);
        rd_chk(idx_ctl, 8'h12);
        wr(idx_ctl, 8'h02);
        rd_chk(idx_ctl, 8'h02);
    endtask
    task automatic t_updown();
        period_compare_value <= 16'h0003;
        wr(idx_set, 8'h44);
        restart(8'h03);
        ticks(3);
        rd_chk(idx_lo, 8'h03);
        ticks(2);
        rd_chk(idx_lo, 8'h01);
        rd_chk(idx_ctl, 8'h03);
        ticks(1);
        rd_chk(idx_ctl, 8'h33);
    endtask
    task automatic t_outputs();
        logic [7:0] e;
        period_compare_value <= 16'h0004;
        wr(idx_set, 8'h4C);
        restart(8'h02);
        ticks(5);
        out_chk(1'b0);
        wr(idx_set, 8'h44);
        ticks(5);
        out_chk(1'b1);
        wr(idx_set, 8'h4C);
        ticks(5);
        out_chk(1'b0);
        wr(idx_set, 8'h54);
        ticks(5);
        out_chk(1'b1);
        ticks(5);
        out_chk(1'b0);
        e = out_edges;
        for (int a = 5; a < 8; a++) begin
            wr(idx_set, {2'b01, a[2:0], 3'b100});
            ticks(5);
        end
        check(out_edges, e);
        wr(idx_set, 8'h5C);
        ticks(4);
        out_chk(1'b1);
        ticks(1);
        out_chk(1'b0);
        wr(idx_set, 8'h64);
        ticks(5);
        out_chk(1'b1);
    endtask
    task automatic t_capture();
        restart(8'h01);
        ticks(9);
        wr(idx_ctl, 8'h00);
        for (int e = 0; e < 4; e++) begin
            wr(idx_set, {6'h00, e[1:0]});
            pin(1'b1);
            check(event_flags[1], e[0]);
            wr(idx_ctl, 8'h00);
            pin(1'b0);
            check(event_flags[1], e[1]);
            wr(idx_ctl, 8'h00);
        end
        check(capture_value, 16'h0009);
        check(chan0_irq_enable, 1'b0);
        wr(idx_set, 8'h07);
        pin(1'b1);
        check(event_flags[1], 1'b0);
        wr(idx_set, 8'h81);
        pin(1'b0);
        pin(1'b1);
        radio(8'h02);
        check(event_flags[1], 1'b0);
        radio(8'h01);
        check(event_flags[1], 1'b1);
        wr(idx_ctl, 8'h00);
        @(posedge clk);
        chan1_event <= 1'b1;
        chan2_event <= 1'b1;
        @(posedge clk);
        chan1_event <= 1'b0;
        chan2_event <= 1'b0;
        rd_chk(idx_ctl, 8'hC0);
    endtask
    // ============================================================
    // main sequence and timeout
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_prescale();
        t_snapshot();
        t_modulo();
        t_updown();
        t_outputs();
        t_capture();
        results();
    end
endmodule

// >>> tb/tmr1_monitor.sv
`timescale 1ns/1ps
`include "tmr1_cfg.svh"
module tmr1_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`TMR1_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic tick_enable,
    input wire logic [15:0] period_compare_value,
    input wire logic chan1_event,
    input wire logic chan2_event,
    input wire logic chan0_out,
    input wire logic capture_strobe,
    input wire logic [15:0] tick_count,
    input wire logic chan0_irq_enable,
    input wire logic [3:0] event_flags
);
    // ============================================================
    // helpers and sequences
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [7:0] low_q;
    always_ff @(posedge clk) begin
        low_q <= tick_count[7:0];
    end
    sequence s_req;
        $rose(avs_read) || $rose(avs_write);
    endsequence
    sequence s_low_write;
        avs_write && !avs_waitrequest && avs_address == 10'h388
            && avs_byteenable[0];
    endsequence
    sequence s_terminal;
        tick_count != 16'h0000 && (tick_count == period_compare_value
            || tick_count == 16'hFFFF);
    endsequence
    sequence s_to_zero;
        tick_count == 16'h0000 && !$past(avs_write);
    endsequence
    // ============================================================
    // properties
    property p_one_wait;
        s_req |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    property p_idle;
        !avs_read && !avs_write |-> !avs_waitrequest;
    endproperty
    property p_clear;
        s_low_write |=> tick_count == 16'h0000;
    endproperty
    property p_read_low;
        $rose(avs_read) && avs_address == 10'h388
            |=> avs_readdata == {24'h000000, low_q};
    endproperty
    property p_hold;
        !tick_enable && !avs_write |=> $stable(tick_count);
    endproperty
    property p_chan1;
        chan1_event |=> event_flags[2];
    endproperty
    property p_chan2;
        chan2_event |=> event_flags[3];
    endproperty
    property p_wrap;
        s_terminal ##1 s_to_zero |-> event_flags[0];
    endproperty
    property p_strobe;
        capture_strobe |-> event_flags[1];
    endproperty
    property p_out;
        $changed(chan0_out) |-> tick_count == period_compare_value
            || tick_count == 16'h0000
            || $past(tick_count) == $past(period_compare_value)
            || $past(tick_count) == 16'h0000;
    endproperty
    property p_irq_rst;
        $fell(reset) |-> chan0_irq_enable;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("request not answered after one wait state");
    a_idle: assert property (p_idle)
        else $error("waitrequest high while idle");
    a_clear: assert property (p_clear)
        else $error("count not cleared by low byte write");
    a_read_low: assert property (p_read_low)
        else $error("low byte read differs from count");
    a_hold: assert property (p_hold)
        else $error("count moved without a tick");
    a_chan1: assert property (p_chan1)
        else $error("channel 1 flag not set");
    a_chan2: assert property (p_chan2)
        else $error("channel 2 flag not set");
    a_wrap: assert property (p_wrap)
        else $error("wrap flag not set at terminal step");
    a_strobe: assert property (p_strobe)
        else $error("capture without channel 0 flag");
    a_out: assert property (p_out)
        else $error("output moved away from a match");
    a_irq_rst: assert property (p_irq_rst)
        else $error("interrupt enable not set after reset");
endmodule
bind tmr1_core tmr1_monitor i_monitor (.clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .tick_enable, .period_compare_value, .chan1_event,
    .chan2_event, .chan0_out, .capture_strobe, .tick_count,
    .chan0_irq_enable, .event_flags);

// >>> tb/tmr1_pin_partner.sv
`timescale 1ns/1ps
module tmr1_pin_partner (
    input wire logic clk,
    input wire logic pin_level,
    input wire logic chan0_out,
    output logic capture_pin,
    output logic [7:0] out_edges
);
    // ============================================================
    // capture pin driver and output edge counter
    logic out_q = 1'b0;
    initial capture_pin = 1'b0;
    initial out_edges = 8'h00;
    always @(posedge clk) begin
        capture_pin <= pin_level;
        out_q <= chan0_out;
        if (chan0_out !== out_q) begin
            out_edges <= out_edges + 8'h01;
        end
    end
endmodule
